// ---- hdl/irc_pkg.sv ----
// constants and carrier types for the infrared pulse codec
package irc_pkg;

	// apb geometry
	localparam int          ADDR_W        = 12;
	localparam int          DATA_W        = 32;

	// register indices, byte address is four times the index
	localparam logic [9:0]  IDX_EVENT_SOURCE_SELECT     = 10'h000;
	localparam logic [9:0]  IDX_TXLEN     = 10'h001;
	localparam logic [9:0]  IDX_RXFILT    = 10'h002;
	localparam logic [9:0]  IDX_STATUS    = 10'h003;

	// reset values
	localparam logic [3:0]  EVENT_SOURCE_SELECT_RST     = 4'h0;
	localparam logic [7:0]  TXLEN_RST     = 8'h00;
	localparam logic [7:0]  RXFILT_RST    = 8'h00;

	// field layout of the event select register
	localparam int          EVENT_SOURCE_SELECT_W       = 4;
	localparam int          EVENT_SOURCE_SELECT_ON_BIT  = 3;

	// transmit pulse length codes
	localparam logic [7:0]  TXLEN_316     = 8'h00;
	localparam logic [7:0]  TXLEN_OFF     = 8'hff;
	localparam logic [7:0]  OS_TICKS_316  = 8'h03;

	// receive filter code for bypass
	localparam logic [7:0]  RXFILT_BYPASS = 8'h00;

	// serial port communication modes
	localparam logic [1:0]  COMMUNICATION_MODE_ASYNC   = 2'b00;
	localparam logic [1:0]  COMMUNICATION_MODE_SYNC    = 2'b01;
	localparam logic [1:0]  COMMUNICATION_MODE_IR      = 2'b10;
	localparam logic [1:0]  COMMUNICATION_MODE_MSPI    = 2'b11;

	// signals from one serial port towards the codec
	typedef struct packed
	{
		logic [1:0] communication_mode;
		logic       tx_data;
		logic       baud_clk;
		logic       os_tick;
	} irc_port_s;

	// apb request as seen by the slave
	typedef struct packed
	{
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} irc_apb_req_s;

endpackage

// ---- hdl/irc_tx_shaper.sv ----
// transmit pulse shaper: one pulse per zero bit
`timescale 1ns/1ns
`default_nettype none
module irc_tx_shaper
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       run,
	input  wire logic       start,
	input  wire logic       os_tick,
	input  wire logic [7:0] len,
	output logic            pulse
);
	import irc_pkg::*;

	logic       pulse_reg;
	logic [7:0] cnt_reg;
	logic [8:0] wid_reg;

	assign pulse = pulse_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pulse_reg <= 1'b0;
			cnt_reg   <= 8'h00;
		end
		else if (!run)
		begin
			pulse_reg <= 1'b0;
			cnt_reg   <= 8'h00;
		end
		else if (start && !pulse_reg)
		begin
			pulse_reg <= 1'b1;
			cnt_reg   <= (len == TXLEN_316) ? OS_TICKS_316 : len;
		end
		else if (pulse_reg && (len != TXLEN_316 || os_tick))
		begin
			cnt_reg <= cnt_reg - 8'h01;
			if (cnt_reg == 8'h01)
				pulse_reg <= 1'b0;
		end
	end

	// width of the current pulse, checked below
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wid_reg <= 9'h000;
		else
			wid_reg <= pulse_reg ? wid_reg + 9'h001 : 9'h000;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_start;
		run && start && !pulse_reg |=> pulse_reg;
	endproperty
	a_start: assert property (p_start) else $error("pulse did not start on baud edge");

	property p_fixed_len;
		run && len != TXLEN_316 && len != TXLEN_OFF && $fell(pulse_reg) |-> wid_reg == {1'b0, len};
	endproperty
	a_fixed_len: assert property (p_fixed_len) else $error("fixed pulse length wrong");

	property p_316_end;
		run && len == TXLEN_316 && $fell(pulse_reg) |-> $past(os_tick);
	endproperty
	a_316_end: assert property (p_316_end) else $error("3/16 pulse ended off tick");
endmodule
`default_nettype wire

// ---- hdl/irc_rx_filter.sv ----
// receive pulse width filter
`timescale 1ns/1ns
`default_nettype none
module irc_rx_filter
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       pulse_in,
	input  wire logic [7:0] coef,
	output logic            pulse_out
);
	import irc_pkg::*;

	logic       last_reg;
	logic [7:0] cnt_reg;
	logic       out_reg;

	assign pulse_out = out_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			last_reg <= 1'b0;
			cnt_reg  <= 8'h00;
			out_reg  <= 1'b0;
		end
		else if (coef == RXFILT_BYPASS)
		begin
			last_reg <= pulse_in;
			cnt_reg  <= 8'h00;
			out_reg  <= pulse_in;
		end
		else if (pulse_in != last_reg)
		begin
			last_reg <= pulse_in;
			cnt_reg  <= 8'h00;
		end
		else
		begin
			if (cnt_reg != coef)
				cnt_reg <= cnt_reg + 8'h01;
			// coef+1 equal samples reached
			if (cnt_reg == coef - 8'h01 || cnt_reg == coef)
				out_reg <= pulse_in;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_bypass;
		coef == RXFILT_BYPASS |=> out_reg == $past(pulse_in);
	endproperty
	a_bypass: assert property (p_bypass) else $error("filter bypass broken");

	property p_reject;
		coef != RXFILT_BYPASS && pulse_in != last_reg |=> out_reg == $past(out_reg);
	endproperty
	a_reject: assert property (p_reject) else $error("short pulse passed");

	property p_count;
		$past(coef) != RXFILT_BYPASS && coef == $past(coef) && out_reg != $past(out_reg)
			|-> $past(cnt_reg) == coef - 8'h01;
	endproperty
	a_count: assert property (p_count) else $error("accepted before x+1 samples");
endmodule
`default_nettype wire

// ---- hdl/irc_infrared_codec.sv ----
// infrared pulse codec top: apb registers, port routing, shaper and filter
//
// How it works
// - the codec switches on by itself when a serial port picks infrared mode and then sits between that port and its pins.
// - pin levels are the inverse of the infrared pulse sent or received.
// - an event source with bit 3 set (1nnn) makes the receiver decode from event channel n instead of the pin.
// - transmit length zero gives pulses of three sixteenths of a baud period.
// - transmit length 1 to 254 gives pulses of exactly that many clock periods.
// - each pulse starts on the rising edge of the baud clock.
// - transmit length 255 turns coding off so both directions pass straight through.
// - the length and filter settings change nothing while no port is in infrared mode.
// - a received pulse counts as zero only if wide enough, otherwise the bit reads as one.
// - filter zero bypasses filtering, a value x needs x+1 equal samples.
// - event select 0000 means none, 0001 to 0111 are reserved, 1nnn picks channel n.
// - mode code 10 is infrared, 00 async, 01 sync, 11 master spi.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module irc_infrared_codec
#(
	parameter int NUM_PORTS = 2,
	parameter int SELW      = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1
)
(
	input  wire logic                               pclk,
	input  wire logic                               presetn,
	input  wire irc_pkg::irc_apb_req_s              apb_req,
	output logic [irc_pkg::DATA_W-1:0]              prdata,
	output logic                                    pready,
	output logic                                    pslverr,
	input  wire irc_pkg::irc_port_s [NUM_PORTS-1:0] port_in,
	output logic [NUM_PORTS-1:0]                    port_rx,
	input  wire logic [NUM_PORTS-1:0]               pin_rx,
	output logic [NUM_PORTS-1:0]                    pin_tx,
	input  wire logic [7:0]                         event_chan
);
	import irc_pkg::*;

	function automatic logic irc_is_ir(input logic [1:0] mode);
		irc_is_ir = (mode == COMMUNICATION_MODE_IR);
	endfunction

	function automatic logic irc_hit(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
		irc_hit = (addr[1:0] == 2'b00) && (addr[ADDR_W-1:2] == idx);
	endfunction

	// registers
	logic [EVENT_SOURCE_SELECT_W-1:0]   event_source_select_reg;
	logic [7:0]           txlen_reg;
	logic [7:0]           rxfilt_reg;
	logic                 pready_reg;
	logic                 pslverr_reg;
	logic [DATA_W-1:0]    prdata_reg;
	logic [NUM_PORTS-1:0] baud_q_reg;
	logic [NUM_PORTS-1:0] pin_tx_reg;
	logic [NUM_PORTS-1:0] port_rx_reg;

	// combinational
	logic                 active;
	logic [SELW-1:0]      sel;
	logic                 coding;
	logic                 ev_on;
	logic                 rx_src;
	logic                 tx_start;
	logic                 tx_pulse;
	logic                 rx_pulse;
	logic                 req_first;
	logic                 req_done;
	logic                 mapped;

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;
	assign pin_tx  = pin_tx_reg;
	assign port_rx = port_rx_reg;

	// lowest port in infrared mode owns the codec
	always_comb
	begin
		active = 1'b0;
		sel    = '0;
		for (int i = NUM_PORTS - 1; i >= 0; i--)
		begin
			if (irc_is_ir(port_in[i].communication_mode))
			begin
				active = 1'b1;
				sel    = SELW'(i);
			end
		end
	end

	assign coding = active && (txlen_reg != TXLEN_OFF);
	assign ev_on  = event_source_select_reg[EVENT_SOURCE_SELECT_ON_BIT];
	assign rx_src = ev_on ? event_chan[event_source_select_reg[2:0]] : pin_rx[sel];

	// apb slave
	assign req_first = apb_req.psel && apb_req.penable && !pready_reg;
	assign req_done  = apb_req.psel && apb_req.penable && pready_reg;
	assign mapped    = irc_hit(apb_req.paddr, IDX_EVENT_SOURCE_SELECT) || irc_hit(apb_req.paddr, IDX_TXLEN)
		|| irc_hit(apb_req.paddr, IDX_RXFILT) || irc_hit(apb_req.paddr, IDX_STATUS);

	// one wait state on every access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			pready_reg  <= req_first;
			pslverr_reg <= req_first && !mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_reg <= '0;
		else if (req_first && !apb_req.pwrite)
		begin
			prdata_reg <= '0;
			if (irc_hit(apb_req.paddr, IDX_EVENT_SOURCE_SELECT))
				prdata_reg[EVENT_SOURCE_SELECT_W-1:0] <= event_source_select_reg;
			else if (irc_hit(apb_req.paddr, IDX_TXLEN))
				prdata_reg[7:0] <= txlen_reg;
			else if (irc_hit(apb_req.paddr, IDX_RXFILT))
				prdata_reg[7:0] <= rxfilt_reg;
			else if (irc_hit(apb_req.paddr, IDX_STATUS))
				prdata_reg[SELW:0] <= {sel, active};
		end
	end

	// writes land on the completing edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			event_source_select_reg  <= EVENT_SOURCE_SELECT_RST;
			txlen_reg  <= TXLEN_RST;
			rxfilt_reg <= RXFILT_RST;
		end
		else if (req_done && apb_req.pwrite && !pslverr_reg)
		begin
			// upper bits of the event select are not stored
			if (irc_hit(apb_req.paddr, IDX_EVENT_SOURCE_SELECT))
				event_source_select_reg <= apb_req.pwdata[EVENT_SOURCE_SELECT_W-1:0];
			if (irc_hit(apb_req.paddr, IDX_TXLEN))
				txlen_reg <= apb_req.pwdata[7:0];
			if (irc_hit(apb_req.paddr, IDX_RXFILT))
				rxfilt_reg <= apb_req.pwdata[7:0];
		end
	end

	// transmit
	// previous baud level of every port, for rising edge detection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			baud_q_reg <= '0;
		else
			for (int i = 0; i < NUM_PORTS; i++)
				baud_q_reg[i] <= port_in[i].baud_clk;
	end

	// a zero bit starts a pulse at the baud rising edge
	assign tx_start = coding && port_in[sel].baud_clk && !baud_q_reg[sel]
		&& !port_in[sel].tx_data;

	irc_tx_shaper u_tx
	(
		.pclk    (pclk),
		.presetn (presetn),
		.run     (coding),
		.start   (tx_start),
		.os_tick (port_in[sel].os_tick),
		.len     (txlen_reg),
		.pulse   (tx_pulse)
	);

	// receive
	irc_rx_filter u_rx
	(
		.pclk      (pclk),
		.presetn   (presetn),
		.pulse_in  (coding && !rx_src),
		.coef      (rxfilt_reg),
		.pulse_out (rx_pulse)
	);

	// per-port routing
	genvar g;
	generate
		for (g = 0; g < NUM_PORTS; g++)
		begin : g_port
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					pin_tx_reg[g]  <= 1'b1;
					port_rx_reg[g] <= 1'b1;
				end
				else if (active && sel == SELW'(g))
				begin
					// idle pin is high, pulse drives it low
					pin_tx_reg[g]  <= coding ? !tx_pulse : port_in[g].tx_data;
					port_rx_reg[g] <= coding ? !rx_pulse : rx_src;
				end
				else
				begin
					pin_tx_reg[g]  <= port_in[g].tx_data;
					port_rx_reg[g] <= pin_rx[g];
				end
			end
		end
	endgenerate

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup;
		apb_req.psel && !apb_req.penable;
	endsequence

	sequence s_access;
		apb_req.psel && apb_req.penable && !pready_reg;
	endsequence

	property p_apb_answer;
		s_setup ##1 s_access |=> pready_reg;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("apb answer not after one wait");

	property p_apb_err;
		req_first && !mapped |=> pslverr_reg && pready_reg;
	endproperty
	a_apb_err: assert property (p_apb_err) else $error("unmapped access not flagged");

	property p_apb_write;
		req_done && apb_req.pwrite && !pslverr_reg && irc_hit(apb_req.paddr, IDX_RXFILT)
			|=> rxfilt_reg == $past(apb_req.pwdata[7:0]);
	endproperty
	a_apb_write: assert property (p_apb_write) else $error("filter write lost");

	// pin goes low two edges after the baud rise is seen
	property p_tx_edge;
		coding && tx_start |=> ##1 pin_tx[$past(sel, 2)] == 1'b0;
	endproperty
	a_tx_edge: assert property (p_tx_edge) else $error("pulse not aligned to baud edge");

	property p_tx_invert;
		coding |=> pin_tx[$past(sel)] == !$past(tx_pulse);
	endproperty
	a_tx_invert: assert property (p_tx_invert) else $error("tx pin not inverse of pulse");

	property p_tx_pass;
		active && txlen_reg == TXLEN_OFF |=> pin_tx[$past(sel)] == $past(port_in[sel].tx_data);
	endproperty
	a_tx_pass: assert property (p_tx_pass) else $error("tx pass-through altered");

	property p_idle_route;
		!active |=> pin_tx == $past(baud_q_next_tx()) && port_rx == $past(pin_rx);
	endproperty
	a_idle_route: assert property (p_idle_route) else $error("settings leaked while idle");

	function automatic logic [NUM_PORTS-1:0] baud_q_next_tx();
		for (int i = 0; i < NUM_PORTS; i++)
			baud_q_next_tx[i] = port_in[i].tx_data;
	endfunction

	property p_event_rx;
		active && txlen_reg == TXLEN_OFF && ev_on
			|=> port_rx[$past(sel)] == $past(event_chan[event_source_select_reg[2:0]]);
	endproperty
	a_event_rx: assert property (p_event_rx) else $error("event channel not used");

	property p_reserved_ev;
		active && txlen_reg == TXLEN_OFF && !ev_on
			|=> port_rx[$past(sel)] == $past(pin_rx[sel]);
	endproperty
	a_reserved_ev: assert property (p_reserved_ev) else $error("pin input not used");

	property p_rx_decode;
		coding |=> port_rx[$past(sel)] == !$past(rx_pulse);
	endproperty
	a_rx_decode: assert property (p_rx_decode) else $error("rx decode wrong");

	property p_auto_on;
		active |-> irc_is_ir(port_in[sel].communication_mode);
	endproperty
	a_auto_on: assert property (p_auto_on) else $error("codec owner not in ir mode");
endmodule
`default_nettype wire

// ---- tb/irc_ir_xcvr.sv ----
// infrared transceiver model: flashes on the receive pin, measures transmit pulses
`timescale 1ns/1ns
`default_nettype none
module irc_ir_xcvr
(
	input  wire logic pclk,
	input  wire logic pin_tx,
	output var logic  pin_rx,
	output var int    last_w
);
	int cnt;

	initial
	begin
		pin_rx = 1'b1;
		last_w = 0;
		cnt = 0;
	end

	// low on the wire is light, width in clock periods
	always @(posedge pclk)
	begin
		if (pin_tx === 1'b0)
			cnt <= cnt + 1;
		else if (cnt != 0)
		begin
			last_w <= cnt;
			cnt <= 0;
		end
	end

	task automatic flash(input int w);
		@(posedge pclk);
		if (w > 0)
		begin
			pin_rx <= 1'b0;
			repeat (w) @(posedge pclk);
			pin_rx <= 1'b1;
		end
	endtask
endmodule
`default_nettype wire

// ---- tb/infrared_pulse_codec_bench.sv ----
// self-checking bench for the infrared pulse codec
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin fails++; \
	$display("MISMATCH %0t %s", $time, m); end end
module infrared_pulse_codec_bench;
	import irc_pkg::*;
	logic                pclk;
	logic                presetn;
	irc_apb_req_s        req;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	irc_port_s [1:0]     port_in;
	logic [1:0]          port_rx;
	logic [1:0]          pin_tx;
	logic [7:0]          event_chan;
	logic                xrx;
	logic [31:0]         rd;
	logic                er;
	logic [1:0]          tk = 2'd0;
	logic [7:0]          xv [3];
	logic [2:0]          n;
	int                  lw;
	int                  irp;
	int                  zc;
	int                  fails;
	int                  total_checks;

	irc_infrared_codec #(.NUM_PORTS(2)) dut_u
	(
		.pclk       (pclk),
		.presetn    (presetn),
		.apb_req    (req),
		.prdata     (prdata),
		.pready     (pready),
		.pslverr    (pslverr),
		.port_in    (port_in),
		.port_rx    (port_rx),
		.pin_rx     ({2{xrx}}),
		.pin_tx     (pin_tx),
		.event_chan (event_chan)
	);

	irc_ir_xcvr xcvr_u
	(
		.pclk   (pclk),
		.pin_tx (pin_tx[irp]),
		.pin_rx (xrx),
		.last_w (lw)
	);

	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// oversampling tick every fourth clock
	always @(posedge pclk)
	begin
		tk <= tk + 2'd1;
		port_in[0].os_tick <= (tk == 2'd3);
		port_in[1].os_tick <= (tk == 2'd3);
	end

	always @(posedge pclk)
		if (port_rx[irp] === 1'b0)
			zc++;

	task automatic print_verdict();
		if (fails == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	// random tx data on both ports, masked ports must follow one cycle later
	task automatic chk_pass(input logic [1:0] m);
		logic [1:0] v;
		logic [1:0] pv;
		for (int i = 0; i < 24; i++)
		begin
			@(posedge pclk);
			v = 2'($urandom);
			port_in[0].tx_data <= v[0];
			port_in[1].tx_data <= v[1];
			#1;
			if (i > 0)
				`CHK(pin_tx & m, pv & m, "pass through")
			pv = v;
		end
		@(posedge pclk);
		port_in[0].tx_data <= 1'b1;
		port_in[1].tx_data <= 1'b1;
	endtask

	task automatic txpulse(input logic [7:0] len);
		int d;
		apb(1'b1, 12'h004, {24'h0, len});
		@(posedge pclk);
		port_in[irp].tx_data <= 1'b0;
		port_in[irp].baud_clk <= 1'b1;
		d = 0;
		do
		begin
			@(posedge pclk);
			d++;
		end
		while (pin_tx[irp] !== 1'b0 && d < 8);
		`CHK(d inside {[1:5]}, 1'b1, "pulse start")
		repeat (31) @(posedge pclk);
		port_in[irp].baud_clk <= 1'b0;
		port_in[irp].tx_data <= 1'b1;
		repeat (300) @(posedge pclk);
	endtask

	task automatic rxpulse(input int w, input logic ev, input logic exp);
		zc = 0;
		if (ev)
		begin
			@(posedge pclk);
			event_chan[n] <= 1'b0;
			repeat (w) @(posedge pclk);
			event_chan <= 8'hff;
		end
		else
			xcvr_u.flash(w);
		repeat (20) @(posedge pclk);
		`CHK(zc > 0, exp, "rx decode")
	endtask

	initial
	begin
		void'($urandom(32'h7c81));
		presetn = 1'b0;
		req = '0;
		port_in = {2{5'b00100}};
		event_chan = 8'hff;
		irp = 0;
		zc = 0;
		fails = 0;
		total_checks = 0;
		repeat (10) @(posedge pclk);
		`CHK({pin_tx, port_rx}, 4'hf, "idle in reset")
		presetn <= 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b0, 12'(4 * i), 32'h0);
			`CHK(rd, 32'h0, "reset value")
		end
		apb(1'b0, 12'h010, 32'h0);
		`CHK({er, rd}, {1'b1, 32'h0}, "unmapped")
		apb(1'b1, 12'h008, 32'h0000_0004);
		chk_pass(2'b11);
		irp = $urandom_range(1, 0);
		port_in[irp].communication_mode <= COMMUNICATION_MODE_IR;
		port_in[1 - irp].communication_mode <= ($urandom_range(1, 0) ? COMMUNICATION_MODE_SYNC : COMMUNICATION_MODE_MSPI);
		apb(1'b0, 12'h00c, 32'h0);
		`CHK(rd, 32'(irp * 2 + 1), "owner")
		xv = '{8'h01, 8'hfe, 8'($urandom_range(253, 2))};
		foreach (xv[i])
		begin
			txpulse(xv[i]);
			`CHK(lw, int'(xv[i]), "fixed width")
		end
		txpulse(TXLEN_316);
		`CHK(lw inside {[8:14]}, 1'b1, "3/16 width")
		apb(1'b1, 12'h004, 32'h0000_00ff);
		chk_pass(2'b11);
		apb(1'b1, 12'h004, 32'h0000_0005);
		xv = '{8'h00, 8'($urandom_range(6, 1)), 8'hff};
		foreach (xv[i])
		begin
			apb(1'b1, 12'h008, {24'h0, xv[i]});
			rxpulse(int'(xv[i]), 1'b0, 1'b0);
			rxpulse(int'(xv[i]) + 1, 1'b0, 1'b1);
		end
		apb(1'b1, 12'h008, 32'h0);
		n = 3'($urandom);
		apb(1'b1, 12'h000, {28'h0, 1'b1, n});
		apb(1'b0, 12'h000, 32'h0);
		`CHK(rd, {28'h0, 1'b1, n}, "event select")
		rxpulse(2, 1'b1, 1'b1);
		rxpulse(2, 1'b0, 1'b0);
		apb(1'b1, 12'h004, 32'h0000_00ff);
		rxpulse(2, 1'b1, 1'b1);
		apb(1'b1, 12'h000, 32'h0000_0003);
		rxpulse(2, 1'b0, 1'b1);
		print_verdict();
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		fails++;
		print_verdict();
	end
endmodule
`default_nettype wire
